// file: logic/edmi_core.sv
// External data memory interface: address generation, on-chip RAM and off-chip bus
// ======================================
`include "edmi_consts.svh"
module edmi_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        instr_valid,
    output logic             instr_ready,
    input  wire logic        instr_wide,
    input  wire logic        instr_write,
    input  wire logic [7:0]  instr_index,
    input  wire logic [7:0]  instr_wdata,
    output logic             instr_done,
    output logic [7:0]       instr_rdata,
    output logic             flash_wr_valid,
    output logic [15:0]      flash_wr_addr,
    output logic [7:0]       flash_wr_data,
    input  wire logic [7:0]  p1_latch,
    input  wire logic [7:0]  p1_xbar_oe,
    output logic [7:0]       p1_out,
    output logic [7:0]       p1_oe,
    input  wire logic [7:0]  p2_latch,
    input  wire logic [7:0]  p2_xbar_oe,
    output logic [7:0]       p2_out,
    output logic [7:0]       p2_oe,
    input  wire logic [7:0]  p3_latch,
    input  wire logic [7:0]  p3_xbar_oe,
    output logic [7:0]       p3_out,
    output logic [7:0]       p3_oe,
    input  wire logic [7:0]  p4_latch,
    input  wire logic [7:0]  p4_xbar_oe,
    input  wire logic [7:0]  p4_in,
    output logic [7:0]       p4_out,
    output logic [7:0]       p4_oe
);
    // ======================================
    // Registers
    logic [7:0]            ext_mem_page_reg;
    logic [7:0]            ext_mem_config_reg;
    logic [7:0]            pointer_high_byte;
    logic [7:0]            pointer_low_byte;
    logic [7:0]            ram [`EDMI_RAM_WORDS];
    edmi_pkg::edmi_state_t state;
    edmi_pkg::edmi_state_t next_state;
    logic [15:0]           addr;
    logic [7:0]            wdata;
    logic                  is_write;
    logic                  hi_drive;
    logic [3:0]            strobe_cnt;

    wire [15:0] wide_data_pointer = {pointer_high_byte, pointer_low_byte};
    wire        nonmux   = ext_mem_config_reg[`EDMI_CFG_NONMUX];
    wire        flash_we = ext_mem_config_reg[`EDMI_CFG_FLASH_WE];
    wire edmi_pkg::edmi_mode_t mode = edmi_pkg::edmi_mode_t'(
        ext_mem_config_reg[`EDMI_CFG_MODE_HI:`EDMI_CFG_MODE_LO]);

    // ======================================
    // Register bus
    wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_take = s_axi_arvalid && !s_axi_rvalid;
    wire wr_page = wr_take && s_axi_awaddr == `EDMI_OFS_PAGE && s_axi_wstrb[0];
    wire wr_cfg  = wr_take && s_axi_awaddr == `EDMI_OFS_CONFIG && s_axi_wstrb[0];
    wire wr_ph   = wr_take && s_axi_awaddr == `EDMI_OFS_PTR_HI && s_axi_wstrb[0];
    wire wr_pl   = wr_take && s_axi_awaddr == `EDMI_OFS_PTR_LO && s_axi_wstrb[0];
    wire wr_map  = s_axi_awaddr == `EDMI_OFS_PAGE || s_axi_awaddr == `EDMI_OFS_CONFIG
                || s_axi_awaddr == `EDMI_OFS_PTR_HI || s_axi_awaddr == `EDMI_OFS_PTR_LO;
    wire rd_map  = s_axi_araddr == `EDMI_OFS_PAGE || s_axi_araddr == `EDMI_OFS_CONFIG
                || s_axi_araddr == `EDMI_OFS_PTR_HI || s_axi_araddr == `EDMI_OFS_PTR_LO
                || s_axi_araddr == `EDMI_OFS_STATUS;
    wire [7:0] rd_byte =
        s_axi_araddr == `EDMI_OFS_PAGE   ? ext_mem_page_reg :
        s_axi_araddr == `EDMI_OFS_CONFIG ? ext_mem_config_reg :
        s_axi_araddr == `EDMI_OFS_PTR_HI ? pointer_high_byte :
        s_axi_araddr == `EDMI_OFS_PTR_LO ? pointer_low_byte :
        s_axi_araddr == `EDMI_OFS_STATUS ? {7'h00, state != edmi_pkg::EDMI_ST_IDLE} :
        8'h00;

    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign s_axi_arready = rd_take;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_mem_page_reg   <= 8'h00;
            ext_mem_config_reg <= `EDMI_CFG_RESET;
            pointer_high_byte  <= 8'h00;
            pointer_low_byte   <= 8'h00;
        end else begin
            if (wr_page) ext_mem_page_reg <= s_axi_wdata[7:0];
            if (wr_cfg) ext_mem_config_reg <= s_axi_wdata[7:0];
            if (wr_ph) pointer_high_byte <= s_axi_wdata[7:0];
            if (wr_pl) pointer_low_byte <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EDMI_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `EDMI_RESP_OKAY;
        end else begin
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `EDMI_RESP_OKAY : `EDMI_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_byte};
                s_axi_rresp  <= rd_map ? `EDMI_RESP_OKAY : `EDMI_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ======================================
    // Address generation and target decode
    wire [15:0] eff_addr = instr_wide ? wide_data_pointer
                                      : {ext_mem_page_reg, instr_index};
    wire in_ram = eff_addr < 16'(`EDMI_RAM_WORDS);
    wire to_ram = mode == edmi_pkg::EDMI_MODE_ONCHIP
               || (mode != edmi_pkg::EDMI_MODE_OFFCHIP && in_ram);
    wire to_flash = flash_we && instr_write;
    wire take = instr_valid && instr_ready;
    // Split mode without bank select leaves the high address pins alone on the short form
    wire next_hi_drive = instr_wide || mode != edmi_pkg::EDMI_MODE_SPLIT;

    assign instr_ready = state == edmi_pkg::EDMI_ST_IDLE;

    // ======================================
    // Access sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            edmi_pkg::EDMI_ST_IDLE:
                if (take && !to_flash) begin
                    if (to_ram) next_state = edmi_pkg::EDMI_ST_ONCHIP;
                    else if (nonmux) next_state = edmi_pkg::EDMI_ST_STROBE;
                    else next_state = edmi_pkg::EDMI_ST_ALE;
                end
            edmi_pkg::EDMI_ST_ONCHIP: next_state = edmi_pkg::EDMI_ST_DONE;
            edmi_pkg::EDMI_ST_ALE:    next_state = edmi_pkg::EDMI_ST_HOLD;
            edmi_pkg::EDMI_ST_HOLD:   next_state = edmi_pkg::EDMI_ST_STROBE;
            edmi_pkg::EDMI_ST_STROBE:
                if (strobe_cnt == 4'(`EDMI_STROBE_CYC - 1)) next_state = edmi_pkg::EDMI_ST_DONE;
            edmi_pkg::EDMI_ST_DONE:   next_state = edmi_pkg::EDMI_ST_IDLE;
            default:                  next_state = edmi_pkg::EDMI_ST_IDLE;
        endcase
    end

    wire ram_wr = state == edmi_pkg::EDMI_ST_ONCHIP && is_write;
    wire sample = state == edmi_pkg::EDMI_ST_STROBE && !is_write
               && strobe_cnt == 4'(`EDMI_STROBE_CYC - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= edmi_pkg::EDMI_ST_IDLE;
            strobe_cnt <= 4'h0;
        end else begin
            state      <= next_state;
            strobe_cnt <= state == edmi_pkg::EDMI_ST_STROBE ? strobe_cnt + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr     <= 16'h0000;
            wdata    <= 8'h00;
            is_write <= 1'b0;
            hi_drive <= 1'b0;
        end else if (take) begin
            addr     <= eff_addr;
            wdata    <= instr_wdata;
            is_write <= instr_write;
            hi_drive <= next_hi_drive;
        end
    end

    always_ff @(posedge aclk) begin
        if (ram_wr) ram[addr[`EDMI_RAM_AW-1:0]] <= wdata;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_rdata    <= 8'h00;
            instr_done     <= 1'b0;
            flash_wr_valid <= 1'b0;
            flash_wr_addr  <= 16'h0000;
            flash_wr_data  <= 8'h00;
        end else begin
            instr_done     <= next_state == edmi_pkg::EDMI_ST_DONE
                           || (take && to_flash);
            flash_wr_valid <= take && to_flash;
            if (take && to_flash) begin
                flash_wr_addr <= eff_addr;
                flash_wr_data <= instr_wdata;
            end
            if (state == edmi_pkg::EDMI_ST_ONCHIP && !is_write)
                instr_rdata <= ram[addr[`EDMI_RAM_AW-1:0]];
            else if (sample)
                instr_rdata <= p4_in;
        end
    end

    // ======================================
    // Pin drive
    wire claim  = state == edmi_pkg::EDMI_ST_ALE || state == edmi_pkg::EDMI_ST_HOLD
               || state == edmi_pkg::EDMI_ST_STROBE;
    wire strobe = state == edmi_pkg::EDMI_ST_STROBE;
    wire [7:0] c1 = !claim ? 8'h00 : nonmux ? `EDMI_P1_NMX_CLAIM : `EDMI_P1_MUX_CLAIM;
    wire [7:0] c2 = claim && nonmux && hi_drive ? 8'hff : 8'h00;
    wire [7:0] c3 = claim && (nonmux || hi_drive) ? 8'hff : 8'h00;
    wire [7:0] c4 = claim ? 8'hff : 8'h00;
    wire [7:0] e1 = {!(strobe && is_write), !(strobe && !is_write),
                     state == edmi_pkg::EDMI_ST_ALE, 5'h00};
    wire [7:0] e3 = nonmux ? addr[7:0] : addr[15:8];
    wire [7:0] e4 = strobe ? wdata : addr[7:0];
    wire [7:0] o4 = (strobe && !is_write) ? 8'h00 : 8'hff;

    // Unclaimed bits fall back to the latch and crossbar; claimed bits are driven, except port 4 during a read strobe
    assign p1_out = (c1 & e1) | (~c1 & p1_latch);
    assign p1_oe  = c1 | p1_xbar_oe;
    assign p2_out = (c2 & addr[15:8]) | (~c2 & p2_latch);
    assign p2_oe  = c2 | p2_xbar_oe;
    assign p3_out = (c3 & e3) | (~c3 & p3_latch);
    assign p3_oe  = c3 | p3_xbar_oe;
    assign p4_out = (c4 & e4) | (~c4 & p4_latch);
    assign p4_oe  = (c4 & o4) | (~c4 & p4_xbar_oe);

    // ======================================
    // Checks
    property p_ptr_hi;
        @(posedge aclk) disable iff (!aresetn)
        wr_ph |=> pointer_high_byte == $past(s_axi_wdata[7:0]);
    endproperty
    a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high byte not written");

    property p_wide_addr;
        @(posedge aclk) disable iff (!aresetn)
        take && instr_wide && !to_flash |=> addr == $past(wide_data_pointer);
    endproperty
    a_wide_addr: assert property (p_wide_addr) else $error("wide address wrong");

    property p_short_addr;
        @(posedge aclk) disable iff (!aresetn)
        take && !instr_wide |=> addr == {$past(ext_mem_page_reg), $past(instr_index)};
    endproperty
    a_short_addr: assert property (p_short_addr) else $error("short address wrong");

    property p_onchip_only;
        @(posedge aclk) disable iff (!aresetn)
        take && !to_flash && mode == edmi_pkg::EDMI_MODE_ONCHIP
        |=> state == edmi_pkg::EDMI_ST_ONCHIP ##1 instr_done && p1_oe == p1_xbar_oe;
    endproperty
    a_onchip_only: assert property (p_onchip_only) else $error("on-chip mode left chip");

    property p_flash;
        @(posedge aclk) disable iff (!aresetn)
        take && instr_write && !flash_we |=> !flash_wr_valid;
    endproperty
    a_flash: assert property (p_flash) else $error("flash written while disabled");

    property p_release;
        @(posedge aclk) disable iff (!aresetn)
        !claim |-> p4_out == p4_latch && p4_oe == p4_xbar_oe && p1_out == p1_latch;
    endproperty
    a_release: assert property (p_release) else $error("pins held outside access");

    property p_read_in;
        @(posedge aclk) disable iff (!aresetn)
        !p1_out[`EDMI_BIT_RD_N] && p1_oe[`EDMI_BIT_RD_N] && claim |-> p4_oe == 8'h00;
    endproperty
    a_read_in: assert property (p_read_in) else $error("data driven during read");

    property p_mux_seq;
        @(posedge aclk) disable iff (!aresetn)
        take && !to_flash && !to_ram && !nonmux
        |=> p1_out[`EDMI_BIT_ALE] && p4_out == addr[7:0]
            ##1 !p1_out[`EDMI_BIT_ALE] && p4_out == addr[7:0] ##1 strobe;
    endproperty
    a_mux_seq: assert property (p_mux_seq) else $error("address latch order wrong");

    property p_nonmux;
        @(posedge aclk) disable iff (!aresetn)
        claim && nonmux |-> p1_out[`EDMI_BIT_ALE] == p1_latch[`EDMI_BIT_ALE]
                         && p3_out == addr[7:0];
    endproperty
    a_nonmux: assert property (p_nonmux) else $error("non-muxed pins wrong");

    property p_mux_hi;
        @(posedge aclk) disable iff (!aresetn)
        claim && !nonmux && hi_drive |-> p3_out == addr[15:8] && p3_oe == 8'hff;
    endproperty
    a_mux_hi: assert property (p_mux_hi) else $error("high address not on port 3");

    property p_bank_hold;
        @(posedge aclk) disable iff (!aresetn)
        claim && !hi_drive |-> (nonmux ? p2_oe == p2_xbar_oe : p3_oe == p3_xbar_oe);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("high address pins claimed");

    property p_done_release;
        @(posedge aclk) disable iff (!aresetn)
        state == edmi_pkg::EDMI_ST_DONE
        |-> p1_oe == p1_xbar_oe && p3_oe == p3_xbar_oe && p4_oe == p4_xbar_oe;
    endproperty
    a_done_release: assert property (p_done_release) else $error("pins kept after move");

    property p_read_sample;
        @(posedge aclk) disable iff (!aresetn)
        sample |=> instr_rdata == $past(p4_in);
    endproperty
    a_read_sample: assert property (p_read_sample) else $error("read byte not taken");
endmodule // edmi_core

// file: common/edmi_consts.svh
// Offsets, field positions, reset values and cycle counts of the memory interface
`ifndef EDMI_CONSTS_SVH
`define EDMI_CONSTS_SVH
`define EDMI_OFS_PAGE      8'h00
`define EDMI_OFS_CONFIG    8'h04
`define EDMI_OFS_PTR_HI    8'h08
`define EDMI_OFS_PTR_LO    8'h0c
`define EDMI_OFS_STATUS    8'h10
`define EDMI_CFG_NONMUX    4
`define EDMI_CFG_MODE_LO   2
`define EDMI_CFG_MODE_HI   3
`define EDMI_CFG_FLASH_WE  5
`define EDMI_CFG_RESET     8'h00
`define EDMI_RAM_WORDS     4096
`define EDMI_RAM_AW        12
`define EDMI_STROBE_NS     10
`define EDMI_CLK_NS        5
`define EDMI_STROBE_CYC    ((`EDMI_STROBE_NS + `EDMI_CLK_NS - 1) / `EDMI_CLK_NS)
`define EDMI_P1_MUX_CLAIM  8'he0
`define EDMI_P1_NMX_CLAIM  8'hc0
`define EDMI_BIT_ALE       5
`define EDMI_BIT_RD_N      6
`define EDMI_BIT_WR_N      7
`define EDMI_RESP_OKAY     2'h0
`define EDMI_RESP_SLVERR   2'h2
`endif

// file: common/edmi_pkg.sv
// Types of the external data memory interface
package edmi_pkg;
    typedef enum logic [1:0] {
        EDMI_MODE_ONCHIP  = 2'h0,
        EDMI_MODE_SPLIT   = 2'h1,
        EDMI_MODE_BANKSEL = 2'h2,
        EDMI_MODE_OFFCHIP = 2'h3
    } edmi_mode_t;
    typedef enum logic [5:0] {
        EDMI_ST_IDLE   = 6'h01,
        EDMI_ST_ONCHIP = 6'h02,
        EDMI_ST_ALE    = 6'h04,
        EDMI_ST_HOLD   = 6'h08,
        EDMI_ST_STROBE = 6'h10,
        EDMI_ST_DONE   = 6'h20
    } edmi_state_t;
endpackage

// file: dv/edmi_sram_model.sv
// Off-chip byte-wide SRAM on the port pins, multiplexed or not
`include "edmi_consts.svh"
module edmi_sram_model (
    input  wire logic       aclk,
    input  wire logic       muxed,
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe,
    input  wire logic [7:0] p2_out,
    input  wire logic [7:0] p3_out,
    input  wire logic [7:0] p4_out,
    input  wire logic [7:0] p4_oe,
    output logic      [7:0] p4_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:65535];
    logic [7:0]  lo_latch;
    logic [7:0]  last;
    logic [15:0] addr;
    logic        ale;
    logic        rd;
    logic        wr;
    assign ale  = p1_oe[`EDMI_BIT_ALE] && p1_out[`EDMI_BIT_ALE];
    assign rd   = p1_oe[`EDMI_BIT_RD_N] && !p1_out[`EDMI_BIT_RD_N];
    assign wr   = p1_oe[`EDMI_BIT_WR_N] && !p1_out[`EDMI_BIT_WR_N];
    assign addr = muxed ? {p3_out, lo_latch} : {p2_out, p3_out};
    // Released data lines show the memory during a read and otherwise the inverse of the last level, never a stale copy
    assign p4_pin = (p4_oe & p4_out) | (~p4_oe & (rd ? mem[addr] : ~last));
    initial begin
        last = 8'h00;
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    end
    always @(posedge aclk) begin
        if (ale) lo_latch <= p4_out;
        if (wr) mem[addr] <= p4_pin;
        last <= p4_pin;
    end
endmodule // edmi_sram_model

// file: dv/edmi_core_tb.sv
// Self-checking bench for the external data memory interface
`include "edmi_consts.svh"
module edmi_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, muxed;
    logic [7:0]  awaddr, araddr, latch, xoe, b;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        i_valid, i_ready, i_wide, i_write, i_done, fl_valid;
    logic [7:0]  i_index, i_wdata, i_rdata, fl_data, fl_d;
    logic [15:0] fl_addr, fl_a;
    logic [7:0]  p1_out, p1_oe, p2_out, p2_oe, p3_out, p3_oe, p4_out, p4_oe, p4_pin;
    int          mismatches, checks, cycles, ale_cnt, claim_cnt, fl_cnt;

    edmi_core uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .instr_valid(i_valid), .instr_ready(i_ready), .instr_wide(i_wide),
        .instr_write(i_write), .instr_index(i_index), .instr_wdata(i_wdata),
        .instr_done(i_done), .instr_rdata(i_rdata), .flash_wr_valid(fl_valid),
        .flash_wr_addr(fl_addr), .flash_wr_data(fl_data),
        .p1_latch(latch), .p1_xbar_oe(xoe), .p1_out(p1_out), .p1_oe(p1_oe),
        .p2_latch(latch), .p2_xbar_oe(xoe), .p2_out(p2_out), .p2_oe(p2_oe),
        .p3_latch(latch), .p3_xbar_oe(xoe), .p3_out(p3_out), .p3_oe(p3_oe),
        .p4_latch(latch), .p4_xbar_oe(xoe), .p4_in(p4_pin), .p4_out(p4_out),
        .p4_oe(p4_oe));

    edmi_sram_model sram (.aclk(aclk), .muxed(muxed), .p1_out(p1_out), .p1_oe(p1_oe),
        .p2_out(p2_out), .p3_out(p3_out), .p4_out(p4_out), .p4_oe(p4_oe),
        .p4_pin(p4_pin));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(negedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge aclk);
    endtask

    task automatic reg_rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd   = rdata;
        resp = rresp;
        @(posedge aclk);
    endtask

    task automatic mem_op(input logic wide, input logic wr, input logic [7:0] idx,
                          input logic [7:0] wd);
        i_valid <= 1'b1;
        i_wide  <= wide;
        i_write <= wr;
        i_index <= idx;
        i_wdata <= wd;
        do @(negedge aclk); while (i_ready !== 1'b1);
        @(posedge aclk);
        i_valid <= 1'b0;
        do @(negedge aclk); while (i_done !== 1'b1);
        b = i_rdata;
        @(posedge aclk);
    endtask

    // ======================================
    // Monitors and hang guard
    always @(posedge aclk) begin
        cycles++;
        if (aresetn && {p1_oe, p2_oe, p3_oe, p4_oe} !== {4{xoe}}) claim_cnt++;
        if (aresetn && p1_oe[`EDMI_BIT_ALE] && p1_out[`EDMI_BIT_ALE]) ale_cnt++;
        if (aresetn && fl_valid === 1'b1) begin
            fl_cnt++;
            fl_a = fl_addr;
            fl_d = fl_data;
        end
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // ======================================
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, arvalid, i_valid, i_wide, i_write} = '0;
        {awaddr, araddr, i_index, i_wdata, wdata} = '0;
        {bready, rready, muxed, wstrb} = 7'h7f;
        latch = 8'hff;
        xoe   = 8'h0f;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_rd(`EDMI_OFS_CONFIG);
        check("config reset", rd, 32'(`EDMI_CFG_RESET));
        check("idle pins", {8'h0, p1_out, p4_out, p4_oe}, {8'h0, latch, latch, xoe});
        reg_rd(8'h20);
        check("unmapped resp", 32'(resp), 32'(`EDMI_RESP_SLVERR));
        reg_wr(8'h14, 32'h55);
        check("unmapped write resp", 32'(resp), 32'(`EDMI_RESP_SLVERR));
        reg_wr(`EDMI_OFS_PTR_HI, 32'h12);
        reg_wr(`EDMI_OFS_PTR_LO, 32'h34);
        reg_wr(`EDMI_OFS_PAGE, 32'h12);
        check("write resp", 32'(resp), 32'(`EDMI_RESP_OKAY));
        reg_rd(`EDMI_OFS_PTR_HI);
        check("pointer high", rd, 32'h12);
        reg_rd(`EDMI_OFS_PTR_LO);
        check("pointer low", rd, 32'h34);
        mem_op(1'b1, 1'b1, 8'h00, 8'h5a);
        mem_op(1'b0, 1'b0, 8'h34, 8'h00);
        check("short read on-chip", 32'(b), 32'h5a);
        reg_wr(`EDMI_OFS_PTR_HI, 32'h02);
        mem_op(1'b1, 1'b0, 8'h00, 8'h00);
        check("on-chip wrap", 32'(b), 32'h5a);
        check("on-chip pins untouched", 32'(claim_cnt), 32'h0);
        // Off-chip only, multiplexed bus
        reg_wr(`EDMI_OFS_CONFIG, 32'h0c);
        reg_wr(`EDMI_OFS_PTR_HI, 32'h56);
        reg_wr(`EDMI_OFS_PTR_LO, 32'h78);
        mem_op(1'b1, 1'b1, 8'h00, 8'ha5);
        check("muxed write", 32'(sram.mem[16'h5678]), 32'ha5);
        check("latch strobes", 32'(ale_cnt), 32'h1);
        check("pins released", {8'h0, p1_out, p1_oe, p4_oe}, {8'h0, latch, xoe, xoe});
        mem_op(1'b1, 1'b0, 8'h00, 8'h00);
        check("muxed read", 32'(b), 32'ha5);
        check("pins claimed", 32'(claim_cnt > 0), 32'h1);
        // Off-chip only, non-multiplexed bus
        muxed <= 1'b0;
        reg_wr(`EDMI_OFS_CONFIG, 32'h1c);
        reg_wr(`EDMI_OFS_PAGE, 32'h9a);
        mem_op(1'b0, 1'b1, 8'hbc, 8'h3c);
        check("non-muxed write", 32'(sram.mem[16'h9abc]), 32'h3c);
        mem_op(1'b0, 1'b0, 8'hbc, 8'h00);
        check("non-muxed read", 32'(b), 32'h3c);
        check("no latch strobe", 32'(ale_cnt), 32'h2);
        // Split modes: above 4 kB goes off-chip, below stays on-chip
        for (int m = 1; m < 3; m++) begin
            reg_wr(`EDMI_OFS_CONFIG, 32'h10 | (m << 2));
            reg_wr(`EDMI_OFS_PTR_HI, 32'h56);
            mem_op(1'b1, 1'b1, 8'h00, 8'(8'h40 + m));
            check("split off-chip", 32'(sram.mem[16'h5678]), 32'(8'h40 + m));
            // Short form: without bank select the high address stays at the parked latch
            mem_op(1'b0, 1'b1, 8'hbc, 8'(8'h50 + m));
            check("split short", 32'(sram.mem[m == 1 ? 16'hffbc : 16'h9abc]), 32'h50 + m);
            reg_wr(`EDMI_OFS_PTR_HI, 32'h00);
            mem_op(1'b1, 1'b1, 8'h00, 8'h66);
            mem_op(1'b1, 1'b0, 8'h00, 8'h00);
            check("split on-chip", {16'h0, b, sram.mem[16'h0078]}, 32'h6600);
        end
        // Flash writes only when enabled; reads stay in data space
        check("no flash yet", 32'(fl_cnt), 32'h0);
        reg_wr(`EDMI_OFS_CONFIG, 32'h20);
        mem_op(1'b1, 1'b1, 8'h00, 8'h99);
        // Let the monitor capture the request before it is compared
        @(posedge aclk);
        check("flash write", {8'(fl_cnt), fl_a, fl_d}, 32'h01007899);
        mem_op(1'b1, 1'b0, 8'h00, 8'h00);
        check("read in data space", 32'(b), 32'h66);
        finish_test();
    end
endmodule // edmi_core_tb
